// ### src/jbc_top.sv
// Joystick to speed command mapping with speed table and brake sequencing
// Assumes joystick samples arrive already digitised, one per valid strobe
//
// Overview of operation
// - Joystick sample taken as already on 0 to 10000 scale
// - Calibration valid only if min<centre<max
// - Inside percent dead band commands stop
// - Outside dead band speed follows deviation
// - Reverse flag inverts direction mapping
// - Exponential curve; zero nonlinearity gives linear
// - Ten-entry speed table, buttons step index
// - Refuse zero entries and out-of-bounds steps
// - Buttons count after over 3 ms held
// - Long idle needs 100 ms outside to leave
// - Host commands run while in dead band
// - Leaving dead band cancels host command
// - Return to dead band runs stop sequence
// - Stop, clamp brake, then cut power; reverse
// - Four configurable millisecond brake delays
// - Brake disabled keeps output released
// - Power-off disabled keeps windings powered
// - Brake config changes act immediately
// - Brake output high means released
module jbc_top (
   // Clock and reset
   input  wire logic                    I_CLK,
   input  wire logic                    I_RESETN,
   // Joystick sample
   input  wire logic [13:0]             I_JOY_VALUE,
   input  wire logic                    I_JOY_VALID,
   input  wire jbc_pkg::jbc_joy_cfg_t   I_JOY_CFG,
   // Buttons and speed table write
   input  wire logic                    I_BTN_LEFT,
   input  wire logic                    I_BTN_RIGHT,
   input  wire logic                    I_TBL_WE,
   input  wire logic [3:0]              I_TBL_ADDR,
   input  wire jbc_pkg::jbc_speed_t     I_TBL_DATA,
   // Host command
   input  wire logic                    I_HOST_CMD,
   input  wire logic                    I_HOST_BUSY,
   // Motion core, brake and outputs
   input  wire jbc_pkg::jbc_brake_cfg_t I_BRAKE_CFG,
   input  wire logic                    I_MOTOR_STOPPED,
   output logic                         O_HOST_ACCEPT,
   output logic                         O_HOST_CANCEL,
   output logic                         O_JOY_ACTIVE,
   output logic                         O_MOVE,
   output logic                         O_DIR_POS,
   output jbc_pkg::jbc_speed_t          O_SPEED,
   output logic [3:0]                   O_TBL_INDEX,
   output logic                         O_CAL_VALID,
   output logic                         O_BRAKE_RELEASE,
   output logic                         O_WINDING_ON,
   output logic                         O_MOTION_READY
);

   // ************************************************************
   // Speed table and index
   // ************************************************************
   jbc_pkg::jbc_speed_t table_mem [jbc_pkg::TABLE_DEPTH];
   logic [3:0] ix_reg, ix_next;
   logic       press_l, press_r;

   jbc_debounce u_deb_left (
      .I_CLK    (I_CLK),
      .I_RESETN (I_RESETN),
      .i_level  (I_BTN_LEFT),
      .o_press  (press_l)
   );

   jbc_debounce u_deb_right (
      .I_CLK    (I_CLK),
      .I_RESETN (I_RESETN),
      .i_level  (I_BTN_RIGHT),
      .o_press  (press_r)
   );

   // Entry is usable when either part nonzero
   function automatic logic nonzero(input jbc_pkg::jbc_speed_t s);
      nonzero = (s.whole != 24'h000000) || (s.frac != 8'h00);
   endfunction

   // Index step with bound and zero-entry refusal
   always_comb begin
      ix_next = ix_reg;
      if (press_r && !press_l) begin
         if (ix_reg != jbc_pkg::TABLE_LAST &&
             nonzero(table_mem[ix_reg + 4'h1]))
            ix_next = ix_reg + 4'h1;
      end else if (press_l && !press_r) begin
         if (ix_reg != 4'h0) ix_next = ix_reg - 4'h1;
      end
   end

   // Table storage, written by host configuration
   always_ff @(posedge I_CLK) begin
      if (I_TBL_WE && I_TBL_ADDR <= jbc_pkg::TABLE_LAST)
         table_mem[I_TBL_ADDR] <= I_TBL_DATA;
   end

   // ************************************************************
   // Joystick deviation and dead band
   // ************************************************************
   logic        cal_ok;
   logic        pos_side;
   logic [13:0] dev, span, dead;
   logic        in_dead;

   // Scale a span by a percentage
   function automatic logic [13:0] pct_of(input logic [13:0] v,
                                          input logic [6:0]  p);
      logic [20:0] prod;
      prod   = 21'(v) * 21'(p);
      pct_of = 14'(prod / 21'd100);
   endfunction

   // Samples are already in the 0..10000 scale; clamp deviation at the calibrated span
   always_comb begin
      cal_ok   = (I_JOY_CFG.low < I_JOY_CFG.mid) &&
                 (I_JOY_CFG.mid < I_JOY_CFG.high) &&
                 (I_JOY_CFG.high <= jbc_pkg::JOY_FULL_SCALE);
      pos_side = I_JOY_VALUE > I_JOY_CFG.mid;
      if (pos_side) begin
         dev  = I_JOY_VALUE - I_JOY_CFG.mid;
         span = I_JOY_CFG.high - I_JOY_CFG.mid;
      end else begin
         dev  = I_JOY_CFG.mid - I_JOY_VALUE;
         span = I_JOY_CFG.mid - I_JOY_CFG.low;
      end
      if (dev > span) dev = span;
      dead    = pct_of(span, I_JOY_CFG.dead_pct);
      in_dead = !cal_ok || dev <= dead;
   end

   // ************************************************************
   // Dead band timing and control ownership
   // ************************************************************
   logic [25:0] idle_reg, idle_next;
   logic [19:0] out_reg,  out_next;
   logic        joy_reg,  joy_next;
   logic        samp_dead_reg, samp_dead_next;

   always_comb begin
      samp_dead_next = I_JOY_VALID ? in_dead : samp_dead_reg;
      idle_next = idle_reg;
      out_next  = 20'h00000;
      joy_next  = joy_reg;
      if (samp_dead_reg) begin
         joy_next = 1'b0;
         if (idle_reg <= 26'(jbc_pkg::IDLE_LONG_CYC))
            idle_next = idle_reg + 26'h0000001;
      end else if (idle_reg > 26'(jbc_pkg::IDLE_LONG_CYC)) begin
         out_next = out_reg + 20'h00001;
         if (out_reg > 20'(jbc_pkg::EXIT_CYC)) begin
            joy_next  = 1'b1;
            idle_next = 26'h0000000;
         end
      end else begin
         joy_next  = 1'b1;
         idle_next = 26'h0000000;
      end
   end

   // ************************************************************
   // Speed curve: linear blended with square by nonlinearity
   // ************************************************************
   jbc_pkg::jbc_speed_t spd_reg, spd_next;
   logic               dir_reg, dir_next;
   logic [31:0]        lin_frac, curve_frac, full;
   logic [63:0]        prod;

   always_comb begin
      // Fraction of span in 16-bit fixed point
      lin_frac = (span == 14'h0000) ? 32'h0 :
                 32'((32'(dev) << 16) / 32'(span));
      // Exponent-like shaping: mix in squared fraction
      curve_frac = 32'((64'(lin_frac) * 64'(lin_frac)) >> 16);
      full = (lin_frac * 32'(8 - 32'(I_JOY_CFG.nonlin)) +
              curve_frac * 32'(I_JOY_CFG.nonlin)) >> jbc_pkg::CURVE_SHIFT;
      prod = 64'(table_mem[ix_reg]) * 64'(full);
      spd_next = in_dead ? '0 : jbc_pkg::jbc_speed_t'(prod[47:16]);
      dir_next = pos_side ^ I_JOY_CFG.reverse;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         ix_reg        <= jbc_pkg::TABLE_RESET_IX;
         idle_reg      <= 26'h0000000;
         out_reg       <= 20'h00000;
         joy_reg       <= 1'b0;
         samp_dead_reg <= 1'b1;
         spd_reg       <= '0;
         dir_reg       <= 1'b0;
      end else begin
         ix_reg        <= ix_next;
         idle_reg      <= idle_next;
         out_reg       <= out_next;
         joy_reg       <= joy_next;
         samp_dead_reg <= samp_dead_next;
         spd_reg       <= spd_next;
         dir_reg       <= dir_next;
      end
   end

   // ************************************************************
   // Brake sequencer and outputs
   // ************************************************************
   jbc_brake_seq u_brake (
      .I_CLK           (I_CLK),
      .I_RESETN        (I_RESETN),
      .i_cfg           (I_BRAKE_CFG),
      .i_want_move     (joy_reg || I_HOST_BUSY),
      .i_motor_stopped (I_MOTOR_STOPPED),
      .o_brake_release (O_BRAKE_RELEASE),
      .o_winding_on    (O_WINDING_ON),
      .o_ready         (O_MOTION_READY)
   );

   // Host handshake and joystick outputs
   assign O_HOST_ACCEPT = I_HOST_CMD && !joy_reg;
   assign O_HOST_CANCEL = joy_reg && I_HOST_BUSY;
   assign O_JOY_ACTIVE  = joy_reg;
   assign O_MOVE        = joy_reg && O_MOTION_READY;
   assign O_DIR_POS     = dir_reg;
   assign O_SPEED       = joy_reg ? spd_reg : '0;
   assign O_TBL_INDEX   = ix_reg;
   assign O_CAL_VALID   = cal_ok;

   chk_index_bound : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      ix_reg <= jbc_pkg::TABLE_LAST)
      else $error("speed index out of table");

   chk_index_step : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      ix_reg != $past(ix_reg) |->
         (ix_reg == $past(ix_reg) + 4'h1) || (ix_reg == $past(ix_reg) - 4'h1))
      else $error("index moved more than one");

   chk_dead_stop : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      samp_dead_reg |=> !joy_reg)
      else $error("joystick active inside dead band");

   chk_host_refused : assert property (@(posedge I_CLK)
      disable iff (!I_RESETN)
      joy_reg |-> !O_HOST_ACCEPT)
      else $error("host command taken under joystick");

endmodule

// ### src/jbc_pkg.sv
// Package of the joystick and brake control block: types and constants
// Assumes a single 10 MHz clock and synchronous active-low reset
package jbc_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_HZ          = 10_000_000;
   localparam int DEBOUNCE_MS     = 3;
   localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int IDLE_LONG_S     = 5;
   localparam int IDLE_LONG_CYC   = IDLE_LONG_S * CLK_HZ;
   localparam int EXIT_MS         = 100;
   localparam int EXIT_CYC        = EXIT_MS * (CLK_HZ / 1000);
   localparam int CYC_PER_MS      = CLK_HZ / 1000;

   // ************************************************************
   // Joystick scale and speed table
   // ************************************************************
   localparam logic [13:0] JOY_FULL_SCALE = 14'h2710;
   localparam int          TABLE_DEPTH    = 10;
   localparam logic [3:0]  TABLE_LAST     = 4'h9;
   localparam logic [3:0]  TABLE_RESET_IX = 4'h0;
   localparam int          CURVE_SHIFT    = 3;

   // Speed value: whole steps and fractional microsteps
   typedef struct packed {
      logic [23:0] whole;
      logic [7:0]  frac;
   } jbc_speed_t;

   // Joystick calibration
   typedef struct packed {
      logic [13:0] low;
      logic [13:0] mid;
      logic [13:0] high;
      logic [6:0]  dead_pct;
      logic [2:0]  nonlin;
      logic        reverse;
   } jbc_joy_cfg_t;

   // Brake timing and enables
   typedef struct packed {
      logic        brake_en;
      logic        poweroff_en;
      logic [15:0] on_to_release_ms;
      logic [15:0] release_to_ready_ms;
      logic [15:0] stop_to_engage_ms;
      logic [15:0] engage_to_off_ms;
   } jbc_brake_cfg_t;

   // Brake sequencer states
   typedef enum logic [2:0] {
      BRK_OFF,
      BRK_POWER_UP,
      BRK_RELEASING,
      BRK_READY,
      BRK_STOP_WAIT,
      BRK_ENGAGED
   } jbc_brake_state_t;

endpackage

// ### src/jbc_debounce.sv
// Button debouncer: a press is reported once the level has held long enough
// Assumes the button input is already synchronous to the clock
module jbc_debounce (
   // Clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RESETN,
   // Button level and press pulse
   input  wire logic i_level,
   output logic      o_press
);

   // ************************************************************
   // Hold counter
   // ************************************************************
   logic [15:0] cnt_reg,  cnt_next;
   logic        done_reg, done_next;

   // Count while active, fire once past the limit
   always_comb begin
      cnt_next  = cnt_reg;
      done_next = done_reg;
      o_press   = 1'b0;
      if (!i_level) begin
         cnt_next  = 16'h0000;
         done_next = 1'b0;
      end else if (!done_reg) begin
         if (cnt_reg > 16'(jbc_pkg::DEBOUNCE_CYC)) begin
            done_next = 1'b1;
            o_press   = 1'b1;
         end else begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end

   // Registers
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         cnt_reg  <= 16'h0000;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   chk_press_held : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      o_press |-> $past(i_level, 8) && i_level)
      else $error("press reported without held level");

endmodule

// ### src/jbc_brake_seq.sv
// Brake and winding power sequencer around motion start and stop
// Assumes millisecond delays in the config may change at any time
module jbc_brake_seq (
   // Clock and reset
   input  wire logic                    I_CLK,
   input  wire logic                    I_RESETN,
   // Configuration and motion demand
   input  wire jbc_pkg::jbc_brake_cfg_t i_cfg,
   input  wire logic                    i_want_move,
   input  wire logic                    i_motor_stopped,
   // Outputs
   output logic                         o_brake_release,
   output logic                         o_winding_on,
   output logic                         o_ready
);

   // ************************************************************
   // State and millisecond timer
   // ************************************************************
   jbc_pkg::jbc_brake_state_t st_reg, st_next;
   logic [13:0] tick_reg, tick_next;
   logic [15:0] ms_reg,   ms_next;
   logic        rel_reg,  rel_next;
   logic        win_reg,  win_next;

   // Time in the current state passed the given delay
   function automatic logic elapsed(input logic [15:0] ms,
                                    input logic [15:0] lim);
      elapsed = ms >= lim;
   endfunction

   // Next state: delays re-evaluated each cycle against live config
   always_comb begin
      st_next   = st_reg;
      tick_next = tick_reg + 14'h0001;
      ms_next   = ms_reg;
      if (tick_reg == 14'(jbc_pkg::CYC_PER_MS - 1)) begin
         tick_next = 14'h0000;
         if (ms_reg != 16'hFFFF) ms_next = ms_reg + 16'h0001;
      end
      case (st_reg)
         jbc_pkg::BRK_OFF: begin
            if (i_want_move) st_next = jbc_pkg::BRK_POWER_UP;
         end
         jbc_pkg::BRK_POWER_UP: begin
            if (elapsed(ms_reg, i_cfg.on_to_release_ms))
               st_next = jbc_pkg::BRK_RELEASING;
         end
         jbc_pkg::BRK_RELEASING: begin
            if (elapsed(ms_reg, i_cfg.release_to_ready_ms))
               st_next = jbc_pkg::BRK_READY;
         end
         jbc_pkg::BRK_READY: begin
            if (!i_want_move && i_motor_stopped)
               st_next = jbc_pkg::BRK_STOP_WAIT;
         end
         jbc_pkg::BRK_STOP_WAIT: begin
            if (i_want_move) st_next = jbc_pkg::BRK_READY;
            else if (elapsed(ms_reg, i_cfg.stop_to_engage_ms))
               st_next = jbc_pkg::BRK_ENGAGED;
         end
         jbc_pkg::BRK_ENGAGED: begin
            if (i_want_move) st_next = jbc_pkg::BRK_POWER_UP;
            else if (!elapsed(ms_reg, i_cfg.stop_to_engage_ms))
               st_next = jbc_pkg::BRK_STOP_WAIT;
            else if (i_cfg.poweroff_en &&
                     elapsed(ms_reg - i_cfg.stop_to_engage_ms,
                             i_cfg.engage_to_off_ms))
               st_next = jbc_pkg::BRK_OFF;
         end
         default: st_next = jbc_pkg::BRK_OFF;
      endcase
      // Timer restarts on entry, except between stop wait and engage in either direction
      if (st_next != st_reg &&
          !(st_reg == jbc_pkg::BRK_STOP_WAIT &&
            st_next == jbc_pkg::BRK_ENGAGED) &&
          !(st_reg == jbc_pkg::BRK_ENGAGED &&
            st_next == jbc_pkg::BRK_STOP_WAIT)) begin
         ms_next   = 16'h0000;
         tick_next = 14'h0000;
      end
      // Brake released high; disabled brake stays released
      rel_next = !i_cfg.brake_en ||
                 (st_next == jbc_pkg::BRK_RELEASING) ||
                 (st_next == jbc_pkg::BRK_READY) ||
                 (st_next == jbc_pkg::BRK_STOP_WAIT);
      // Windings stay on unless power-off enabled and sequence ended
      win_next = (st_next != jbc_pkg::BRK_OFF) || !i_cfg.poweroff_en;
   end

   // Registers
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         st_reg   <= jbc_pkg::BRK_OFF;
         tick_reg <= 14'h0000;
         ms_reg   <= 16'h0000;
         rel_reg  <= 1'b0;
         win_reg  <= 1'b0;
      end else begin
         st_reg   <= st_next;
         tick_reg <= tick_next;
         ms_reg   <= ms_next;
         rel_reg  <= rel_next;
         win_reg  <= win_next;
      end
   end

   assign o_brake_release = rel_reg;
   assign o_winding_on    = win_reg;
   assign o_ready         = (st_reg == jbc_pkg::BRK_READY);

   chk_brake_disabled : assert property (@(posedge I_CLK)
      disable iff (!I_RESETN)
      !i_cfg.brake_en ##1 !$past(i_cfg.brake_en) |-> o_brake_release)
      else $error("brake clamped while disabled");

   chk_ready_released : assert property (@(posedge I_CLK)
      disable iff (!I_RESETN)
      o_ready |-> o_brake_release && o_winding_on)
      else $error("ready without release and power");

   chk_winding_kept : assert property (@(posedge I_CLK)
      disable iff (!I_RESETN)
      !i_cfg.poweroff_en ##1 !$past(i_cfg.poweroff_en) |-> o_winding_on)
      else $error("windings cut with power-off disabled");

endmodule

// ### verification/jbc_partner.sv
// Far-side model: joystick sampler, motion core stop flag, brake converter
// Assumes the bench sets the stick level and watches the magnet power
module jbc_partner (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Stick level and device outputs
   input  wire logic [13:0] i_joy_level,
   input  wire logic        i_move,
   input  wire logic        i_brake_release,
   // Toward the device and the bench
   output logic [13:0]      o_joy_value,
   output logic             o_joy_valid,
   output logic             o_stopped,
   output logic             o_magnet_on
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] smp;
   logic [1:0] idle;
   // Idle values before the first edge
   initial begin
      o_joy_value = 14'h1194;
      o_joy_valid = 1'b0;
      o_stopped   = 1'b1;
   end
   // Sample every 8 cycles; core stands still 4 cycles after move drops
   always @(posedge clk) begin
      if (!resetn) begin
         smp         <= 3'h0;
         idle        <= 2'h0;
         o_joy_valid <= 1'b0;
         o_stopped   <= 1'b1;
      end else begin
         smp         <= smp + 3'h1;
         o_joy_valid <= (smp == 3'h7);
         if (smp == 3'h7) o_joy_value <= i_joy_level;
         idle <= i_move ? 2'h0 : (idle == 2'h3 ? 2'h3 : idle + 2'h1);
         o_stopped   <= !i_move && idle == 2'h3;
      end
   end
   // Converter powers the magnet only while release is high
   assign o_magnet_on = i_brake_release;
endmodule

// ### verification/jbc_top_tb_top.sv
// Bench of the joystick and brake block, one task per scenario
// Assumes jbc_partner for stick, motion core and brake converter
module jbc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Signals and instances
   // ****************************************
   localparam int LIMIT = 140000;
   localparam int MS    = jbc_pkg::CYC_PER_MS;
   localparam int DB    = jbc_pkg::DEBOUNCE_CYC;
   logic                    clk = 1'b0;
   logic                    rstn = 1'b0;
   logic [13:0]             lvl = 14'h1194;
   logic [13:0]             jval;
   logic                    jvld, stp, mag, d1;
   jbc_pkg::jbc_joy_cfg_t   jcfg;
   jbc_pkg::jbc_brake_cfg_t bcfg;
   jbc_pkg::jbc_speed_t     tdat, spd;
   logic [3:0]              taddr, idx;
   logic                    bl = 1'b0, br = 1'b0, we = 1'b0;
   logic                    hcmd = 1'b0, hbusy = 1'b0;
   logic                    acc, canc, jact, mv, dirp, calv, brel, wind, rdy;
   int                      bad_count = 0, checked = 0, cyc = 0, k;
   jbc_top dut (
      .I_CLK(clk), .I_RESETN(rstn), .I_JOY_VALUE(jval), .I_JOY_VALID(jvld),
      .I_JOY_CFG(jcfg), .I_BTN_LEFT(bl), .I_BTN_RIGHT(br), .I_TBL_WE(we),
      .I_TBL_ADDR(taddr), .I_TBL_DATA(tdat), .I_HOST_CMD(hcmd),
      .I_HOST_BUSY(hbusy), .I_BRAKE_CFG(bcfg), .I_MOTOR_STOPPED(stp),
      .O_HOST_ACCEPT(acc), .O_HOST_CANCEL(canc), .O_JOY_ACTIVE(jact),
      .O_MOVE(mv), .O_DIR_POS(dirp), .O_SPEED(spd), .O_TBL_INDEX(idx),
      .O_CAL_VALID(calv), .O_BRAKE_RELEASE(brel), .O_WINDING_ON(wind),
      .O_MOTION_READY(rdy));
   jbc_partner far (
      .clk(clk), .resetn(rstn), .i_joy_level(lvl), .i_move(mv),
      .i_brake_release(brel), .o_joy_value(jval), .o_joy_valid(jvld),
      .o_stopped(stp), .o_magnet_on(mag));
   // Clock and hang limit
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         end_of_test();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic sel(input int s);
      case (s)
         0: return jact;
         1: return brel;
         2: return wind;
         default: return rdy;
      endcase
   endfunction
   // Wait for a watched output to reach a level, counting cycles
   task automatic wt(input int s, input logic v, input int lim);
      for (k = 0; k < lim && sel(s) !== v; k++) @(posedge clk);
   endtask
   task automatic tw(input logic [3:0] a, input logic [23:0] w);
      taddr <= a;
      tdat  <= {w, 8'h00};
      we    <= 1'b1;
      tk(1);
      we    <= 1'b0;
      tk(1);
   endtask
   task automatic press(input logic right);
      if (right) br <= 1'b1;
      else bl <= 1'b1;
      tk(DB + 20);
      br <= 1'b0;
      bl <= 1'b0;
      tk(5);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      tk(2);
      chk("index", 32'h0, idx);
      chk("stick active", 32'h0, jact);
      chk("brake out", 32'h0, brel);
      chk("winding", 32'h0, wind);
      $display("test reset done");
   endtask
   task automatic t_cal;
      jcfg.mid <= 14'h01F4;
      lvl      <= 14'h251C;
      tk(30);
      chk("cal valid", 32'h0, calv);
      chk("stick active", 32'h0, jact);
      lvl      <= 14'h1194;
      tk(20);
      jcfg.mid <= 14'h1194;
      tk(2);
      chk("cal valid", 32'h1, calv);
      $display("test calibration done");
   endtask
   task automatic t_dead;
      lvl  <= 14'h12C0;
      tk(30);
      chk("stick active", 32'h0, jact);
      chk("speed", 32'h0, spd);
      hcmd <= 1'b1;
      tk(1);
      chk("host accept", 32'h1, acc);
      hcmd  <= 1'b0;
      hbusy <= 1'b1;
      lvl   <= 14'h251C;
      wt(0, 1'b1, 20);
      chk("stick active", 32'h1, jact);
      chk("host cancel", 32'h1, canc);
      hcmd <= 1'b1;
      tk(1);
      chk("host accept", 32'h0, acc);
      hcmd  <= 1'b0;
      hbusy <= 1'b0;
      lvl   <= 14'h1194;
      tk(60);
      $display("test dead band done");
   endtask
   task automatic t_speed;
      lvl <= 14'h251C;
      wt(3, 1'b1, 60);
      tk(3);
      chk("move", 32'h1, mv);
      chk("speed high", {24'h000064, 8'h00}, spd);
      d1  = dirp;
      lvl <= 14'h01F4;
      tk(20);
      chk("speed low", {24'h000064, 8'h00}, spd);
      chk("direction", {31'h0, !d1}, dirp);
      jcfg.reverse <= 1'b1;
      tk(20);
      chk("reversed", {31'h0, d1}, dirp);
      jcfg.reverse <= 1'b0;
      lvl <= 14'h1B58;
      tk(20);
      chk("linear half", {24'h000032, 8'h00}, spd);
      jcfg.nonlin <= 3'h4;
      tk(5);
      chk("curved half", 32'h1, spd.whole < 24'h000032);
      jcfg.nonlin <= 3'h0;
      lvl <= 14'h1194;
      tk(40);
      chk("stick active", 32'h0, jact);
      chk("speed", 32'h0, spd);
      $display("test speed curve done");
   endtask
   task automatic t_nobrake;
      bcfg.brake_en    <= 1'b0;
      bcfg.poweroff_en <= 1'b0;
      tk(5);
      chk("brake out", 32'h1, brel);
      chk("winding", 32'h1, wind);
      lvl <= 14'h251C;
      wt(3, 1'b1, 60);
      lvl <= 14'h1194;
      tk(60);
      chk("brake out", 32'h1, brel);
      chk("winding", 32'h1, wind);
      bcfg.brake_en    <= 1'b1;
      bcfg.poweroff_en <= 1'b1;
      tk(20);
      $display("test brake disabled done");
   endtask
   task automatic t_brake;
      bcfg.on_to_release_ms <= 16'h0001;
      bcfg.stop_to_engage_ms <= 16'h0001;
      bcfg.engage_to_off_ms <= 16'h0001;
      tk(2);
      lvl <= 14'h251C;
      wt(2, 1'b1, 40);
      chk("brake before on", 32'h0, brel);
      wt(1, 1'b1, MS + 20);
      chk("on to release", 32'h1, k >= MS - 3 && k <= MS + 4);
      chk("magnet", 32'h1, mag);
      wt(3, 1'b1, 20);
      chk("release to ready", 32'h1, k <= 5);
      lvl <= 14'h1194;
      wt(1, 1'b0, MS + 40);
      chk("stop to engage", 32'h1, k >= MS && k <= MS + 30);
      chk("winding", 32'h1, wind);
      bcfg.stop_to_engage_ms <= 16'h0005;
      tk(5);
      chk("re-release", 32'h1, brel);
      bcfg.stop_to_engage_ms <= 16'h0001;
      wt(1, 1'b0, 20);
      chk("re-engage", 32'h0, brel);
      wt(2, 1'b0, MS + 20);
      chk("engage to off", 32'h1, k >= MS - 40 && k <= MS + 4);
      $display("test brake sequence done");
   endtask
   task automatic t_buttons;
      br <= 1'b1;
      tk(DB - 10);
      chk("index early", 32'h0, idx);
      tk(30);
      chk("index right", 32'h1, idx);
      br <= 1'b0;
      tk(5);
      press(1'b1);
      chk("index zero entry", 32'h1, idx);
      press(1'b0);
      chk("index left", 32'h0, idx);
      $display("test buttons done");
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      jcfg  = '{14'h01F4, 14'h1194, 14'h251C, 7'h0A, 3'h0, 1'b0};
      bcfg  = '{1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      tdat  = 32'h00000000;
      taddr = 4'h0;
      tk(3);
      rstn <= 1'b1;
      t_reset();
      tw(4'h0, 24'h000064);
      tw(4'h1, 24'h0000C8);
      tw(4'h2, 24'h000000);
      t_cal();
      t_dead();
      t_speed();
      t_nobrake();
      t_brake();
      t_buttons();
      end_of_test();
   end
endmodule
